/* verilog/audio_slot_regs.vh */
// Purpose: Offsets, fields, reset values and sync lengths of the audio slot interface
// Assumes: Included by its bare name from every design file that needs it
// Notes: Definitions only
`ifndef AUDIO_SLOT_REGS_VH
`define AUDIO_SLOT_REGS_VH
// Register byte offsets
`define GCR_OFS 8'h00
`define CCR_OFS 8'h04
`define SLOT_OFS 8'h08
`define CSR_OFS 8'h0C
`define TXF_OFS 8'h10
`define RXF_OFS 8'h14
`define TXDMA_OFS 8'h18
`define RXDMA_OFS 8'h28
// global_config_reg fields
`define GCR_EN 0
`define GCR_SYNC 1
`define GCR_NET 2
`define GCR_SLOTS_LO 3
`define GCR_SLOTS_HI 4
`define GCR_W16 5
`define GCR_INT 6
`define GCR_PLL 7
`define GCR_FSL_LO 8
`define GCR_FSL_HI 10
`define GCR_RST 11'h000
// clock_control_reg: bit_clock_divider [7:0], frame_clock_divider [14:8]
`define CCR_RST 15'h0F01
// Slot register: tx assign [3:0], rx assign [7:4], tx dma sel [11:8], rx dma sel [15:12]
`define SLOT_RST 16'h0000
// control_status_reg: thresholds [7:0], pending [11:8], irq enable [19:16], counts [29:20]
`define CSR_THR_RST 8'h00
// Long frame sync lengths in bit clocks
`define FSL_LEN0 7'h06
`define FSL_LEN1 7'h0D
`define FSL_LEN2 7'h0E
`define FSL_LEN3 7'h0F
`define FSL_LEN4 7'h10
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* verilog/slot_word_fifo.v */
// Purpose: Sixteen-entry word ring with read/write pointers and last-access flag
// Assumes: Caller does not push when full unless overrun is acceptable
// Notes: Underrun fetch returns the previous word and leaves the read pointer
`timescale 1ns/1ps
module slot_word_fifo #(
  parameter W = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_srst,
  // Write side
  input wire i_push,
  input wire [W-1:0] i_push_data,
  // Read side
  input wire i_pop,
  output wire [W-1:0] o_rd_data,
  // State
  output wire [AW:0] o_count,
  output wire o_full,
  output wire o_empty
);
  reg [W-1:0] mem_q [0:(1<<AW)-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg last_wr_q;
  wire same = (wr_q == rd_q);
  wire [AW-1:0] diff = wr_q - rd_q;
  wire under = i_pop & o_empty;

  assign o_full = same & last_wr_q;
  assign o_empty = same & ~last_wr_q;
  assign o_count = o_full ? {1'b1, {AW{1'b0}}} : {1'b0, diff};
  assign o_rd_data = under ? mem_q[rd_q - {{(AW-1){1'b0}}, 1'b1}] : mem_q[rd_q];

  // Storage writes
  always @(posedge i_mclk) begin
    if (i_push) begin
      mem_q[wr_q] <= i_push_data;
    end
  end

  // Pointers and last access
  always @(posedge i_mclk) begin
    if (i_srst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      last_wr_q <= 1'b0;
    end else begin
      if (i_push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (i_pop && !under) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (i_push && !i_pop) begin
        last_wr_q <= 1'b1;
      end else if (i_pop && !i_push) begin
        last_wr_q <= 1'b0;
      end
    end
  end
endmodule

/* verilog/axil_reg_port.v */
// Purpose: AXI4-Lite slave front end producing register write and read strobes
// Assumes: Register file answers error flags and read data combinationally
// Notes: One write and one read in flight; address and data taken in any order
`timescale 1ns/1ps
`include "audio_slot_regs.vh"
module axil_reg_port (
  // Clock and reset
  input wire i_mclk,
  input wire i_srst,
  // Write channels
  input wire i_awvalid,
  output reg o_awready,
  input wire [7:0] i_awaddr,
  input wire i_wvalid,
  output reg o_wready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  output reg o_bvalid,
  input wire i_bready,
  output reg [1:0] o_bresp,
  // Read channels
  input wire i_arvalid,
  output reg o_arready,
  input wire [7:0] i_araddr,
  output reg o_rvalid,
  input wire i_rready,
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  // Register side
  output wire o_wr_en,
  output reg [7:0] o_wr_addr,
  output reg [31:0] o_wr_data,
  output reg [3:0] o_wr_strb,
  input wire i_wr_err,
  output wire o_rd_en,
  output reg [7:0] o_rd_addr,
  input wire [31:0] i_rd_data,
  input wire i_rd_err
);
  reg aw_got_q;
  reg w_got_q;
  reg ar_got_q;

  assign o_wr_en = aw_got_q & w_got_q & ~o_bvalid;
  assign o_rd_en = ar_got_q & ~o_rvalid;

  // Write address, data and response
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      o_wr_addr <= 8'h00;
      o_wr_data <= 32'h0000_0000;
      o_wr_strb <= 4'h0;
    end else begin
      if (o_awready && i_awvalid) begin
        o_wr_addr <= i_awaddr;
        o_awready <= 1'b0;
        aw_got_q <= 1'b1;
      end
      if (o_wready && i_wvalid) begin
        o_wr_data <= i_wdata;
        o_wr_strb <= i_wstrb;
        o_wready <= 1'b0;
        w_got_q <= 1'b1;
      end
      if (o_wr_en) begin
        o_bvalid <= 1'b1;
        o_bresp <= i_wr_err ? `RESP_SLVERR : `RESP_OKAY;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // Read address and data
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rresp <= `RESP_OKAY;
      o_rdata <= 32'h0000_0000;
      ar_got_q <= 1'b0;
      o_rd_addr <= 8'h00;
    end else begin
      if (o_arready && i_arvalid) begin
        o_rd_addr <= i_araddr;
        o_arready <= 1'b0;
        ar_got_q <= 1'b1;
      end
      if (o_rd_en) begin
        o_rvalid <= 1'b1;
        o_rdata <= i_rd_data;
        o_rresp <= i_rd_err ? `RESP_SLVERR : `RESP_OKAY;
        ar_got_q <= 1'b0;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
endmodule

/* verilog/audio_slot_serial.v */
// Purpose: Slot-based audio serial interface with FIFOs, per-slot DMA registers and prescalers
// Assumes: i_aux_tick and i_pll_tick are one-cycle strobes of the 12 MHz and 48 MHz sources
// Notes: Serial pins pass two flip-flops; bit clock divider must be 1 or more
`timescale 1ns/1ps
`include "audio_slot_regs.vh"
// Summary of operation
// - Non-DMA slots use receive and transmit FIFOs
// - Receive IRQ when count exceeds threshold
// - Transmit IRQ when count at/below threshold
// - Receive DMA slot fills register, requests
// - Transmit DMA slot reads register, requests empty
// - Synchronous mode: receiver uses transmit clocks
// - Sync network: extra syncs at slots 1,2
// - Bit clock: selected input over divider+1
// - Frame sync: bit clock over divider+1
// - Long sync length 6,13,14,15,16 bits
// - Four pending flags, each gated by its enable, ORed into IRQ
// - Transmit frame sync routed to wake-up
// - Normal mode: one slot; 8-bit words in low byte
// - Frame sync starts transfer, shift on rise
// - Empty slot-0 DMA register resends previous word
// - FIFO fetch at read pointer, then advance
// - FIFO data write stores, advances write pointer
// - Underrun: resend previous, flag, IRQ if enabled
// - Clocks generated internally or taken externally
// - Receive samples on falling bit clock edges
// - Network frames hold up to four slots
// - Receive full: discard word, flag, IRQ if enabled
module audio_slot_serial #(
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_srst,
  // Input clock source strobes
  input wire i_aux_tick,
  input wire i_pll_tick,
  // AXI4-Lite register bus
  input wire i_awvalid,
  output wire o_awready,
  input wire [7:0] i_awaddr,
  input wire i_wvalid,
  output wire o_wready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  output wire o_bvalid,
  input wire i_bready,
  output wire [1:0] o_bresp,
  input wire i_arvalid,
  output wire o_arready,
  input wire [7:0] i_araddr,
  output wire o_rvalid,
  input wire i_rready,
  output wire [31:0] o_rdata,
  output wire [1:0] o_rresp,
  // Serial pins
  input wire i_sck,
  output reg o_sck,
  output reg o_sck_oe,
  input wire i_tx_frame_sync,
  output reg o_tx_frame_sync,
  output reg o_tx_frame_sync_oe,
  input wire i_rx_bit_clock,
  output reg o_rx_bit_clock,
  output reg o_rx_bit_clock_oe,
  input wire i_rx_frame_sync,
  output reg o_rx_frame_sync,
  output reg o_rx_frame_sync_oe,
  output reg o_serial_tx_data,
  output reg o_serial_tx_data_oe,
  input wire i_serial_rx_data,
  // System side
  output reg o_irq,
  output reg o_wakeup_frame_sync,
  output reg [3:0] o_tx_dma_req,
  output reg [3:0] o_rx_dma_req
);
  // Long sync length from code
  function [6:0] fsl_bits(input [2:0] c);
    begin
      case (c)
        3'h0: fsl_bits = `FSL_LEN0;
        3'h1: fsl_bits = `FSL_LEN1;
        3'h2: fsl_bits = `FSL_LEN2;
        3'h3: fsl_bits = `FSL_LEN3;
        default: fsl_bits = `FSL_LEN4;
      endcase
    end
  endfunction

  // Bit index to {in range, slot, position}
  function [6:0] slot_dec(input [6:0] idx, input wide);
    begin
      if (wide) begin
        slot_dec = {~idx[6], idx[5:4], idx[3:0]};
      end else begin
        slot_dec = {~(idx[6] | idx[5]), idx[4:3], 1'b0, idx[2:0]};
      end
    end
  endfunction

  // Byte-lane merge under strobes
  function [31:0] merge(input [31:0] old, input [31:0] d, input [3:0] s);
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (s[k]) begin
          merge[8*k +: 8] = d[8*k +: 8];
        end
      end
    end
  endfunction

  // Per-slot register window {hit, index}
  function [2:0] win(input [7:0] a, input [7:0] base);
    reg [7:0] off;
    begin
      off = a - base;
      win = {(a >= base) && (off < 8'h10) && (a[1:0] == 2'h0), off[3:2]};
    end
  endfunction

  reg [10:0] gcr_q;
  reg [14:0] ccr_q;
  reg [15:0] slot_q;
  reg [7:0] thr_q;
  reg [3:0] ien_q;
  reg rx_ovr_q;
  reg tx_und_q;
  reg [15:0] txdma_q [0:3];
  reg [15:0] rxdma_q [0:3];
  reg [3:0] txfull_q;
  reg [3:0] rxfull_q;
  reg [4:0] pin_s1_q;
  reg [4:0] pin_s2_q;
  reg [4:0] pin_s3_q;
  reg [7:0] pre_q;
  reg [6:0] tbit_q;
  reg tfs_prev_q;
  reg tact_q;
  reg [15:0] tsr_q;
  reg [6:0] rbit_q;
  reg rfs_prev_q;
  reg ract_q;
  reg [15:0] rsr_q;
  reg [31:0] rd_data;
  reg rd_err;
  reg wr_err;
  integer i;

  wire wr_en;
  wire [7:0] wa;
  wire [31:0] wd;
  wire [3:0] ws;
  wire rd_en;
  wire [7:0] ra;
  wire [15:0] txf_rdata;
  wire [15:0] rxf_rdata;
  wire [4:0] txf_cnt;
  wire [4:0] rxf_cnt;
  wire txf_empty;
  wire rxf_full;
  wire rxf_empty;

  wire en = gcr_q[`GCR_EN];
  wire sync_m = gcr_q[`GCR_SYNC];
  wire net_m = gcr_q[`GCR_NET];
  wire w16 = gcr_q[`GCR_W16];
  wire int_m = gcr_q[`GCR_INT];
  wire [1:0] nslot = net_m ? gcr_q[`GCR_SLOTS_HI:`GCR_SLOTS_LO] : 2'h0;
  wire [6:0] fsl_len = fsl_bits(gcr_q[`GCR_FSL_HI:`GCR_FSL_LO]);
  wire [7:0] bdiv = ccr_q[7:0];
  wire [6:0] fdiv = ccr_q[14:8];
  wire [3:0] tx_asg = slot_q[3:0];
  wire [3:0] rx_asg = slot_q[7:4];
  wire [3:0] tx_dsel = slot_q[11:8];
  wire [3:0] rx_dsel = slot_q[15:12];
  wire [31:0] wmask = merge(32'h0000_0000, wd, ws);

  // Pin synchronisers
  wire [4:0] pin_raw = {i_serial_rx_data, i_rx_frame_sync, i_rx_bit_clock, i_tx_frame_sync, i_sck};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : sync_g
      always @(posedge i_mclk) begin
        if (i_srst) begin
          pin_s1_q[g] <= 1'b0;
          pin_s2_q[g] <= 1'b0;
          pin_s3_q[g] <= 1'b0;
        end else begin
          pin_s1_q[g] <= pin_raw[g];
          pin_s2_q[g] <= pin_s1_q[g];
          pin_s3_q[g] <= pin_s2_q[g];
        end
      end
    end
  endgenerate

  wire in_tick = gcr_q[`GCR_PLL] ? i_pll_tick : i_aux_tick;
  wire [8:0] bdiv_p1 = {1'b0, bdiv} + 9'h001;
  wire int_rise = in_tick & (pre_q == bdiv);
  wire int_fall = in_tick & (pre_q != bdiv) & ((pre_q + 8'h01) == bdiv_p1[8:1]);

  wire tx_rise = int_m ? int_rise : (pin_s2_q[0] & ~pin_s3_q[0]);
  wire tx_fall = int_m ? int_fall : (~pin_s2_q[0] & pin_s3_q[0]);
  wire rx_tx_clk = sync_m | int_m;
  wire rx_rise = rx_tx_clk ? tx_rise : (pin_s2_q[2] & ~pin_s3_q[2]);
  wire rx_fall = rx_tx_clk ? tx_fall : (~pin_s2_q[2] & pin_s3_q[2]);

  // Frame length fdiv+1 bits
  // Saturated counter must still restart a frame
  wire tx_start = int_m ? (tbit_q >= fdiv) : (pin_s2_q[1] & ~tfs_prev_q);
  wire [6:0] tidx_d = tx_start ? 7'h00 : ((tbit_q == 7'h7F) ? tbit_q : tbit_q + 7'h01);
  wire tact_d = en & (tact_q | tx_start);
  wire [6:0] tdec = slot_dec(tidx_d, w16);
  wire [1:0] ts = tdec[5:4];
  wire tslot_ok = tact_d & tdec[6] & (ts <= nslot);
  wire tx_mine = tslot_ok & tx_asg[ts];
  wire tx_first = (tdec[3:0] == 4'h0);
  wire tx_load = tx_rise & tx_mine & tx_first;
  wire tx_use_dma = tx_dsel[ts];
  wire [15:0] tx_word = tx_use_dma ? txdma_q[ts] : txf_rdata;
  wire [15:0] tsr_d = tx_first ? tx_word : {tsr_q[14:0], 1'b0};
  // Fetch from FIFO at slot start
  wire txf_pop = tx_load & ~tx_use_dma;
  wire tx_und_evt = txf_pop & txf_empty;
  // Extra syncs in slots 1 and 2
  wire aux_pulse = tslot_ok & ({3'h0, tdec[3:0]} < fsl_len);

  // Transmit path on bit clock rise
  always @(posedge i_mclk) begin
    if (i_srst) begin
      tbit_q <= 7'h00;
      tfs_prev_q <= 1'b0;
      tact_q <= 1'b0;
      tsr_q <= 16'h0000;
      o_serial_tx_data <= 1'b0;
      o_serial_tx_data_oe <= 1'b0;
      o_tx_frame_sync <= 1'b0;
      o_rx_bit_clock <= 1'b0;
      o_rx_frame_sync <= 1'b0;
    end else if (tx_rise) begin
      tbit_q <= tidx_d;
      tfs_prev_q <= pin_s2_q[1];
      tact_q <= tact_d;
      if (tx_mine) begin
        tsr_q <= tsr_d;
        o_serial_tx_data <= w16 ? tsr_d[15] : tsr_d[7];
      end
      o_serial_tx_data_oe <= tx_mine;
      o_tx_frame_sync <= tact_d & (tidx_d < fsl_len);
      o_rx_bit_clock <= aux_pulse & (ts == 2'h1);
      o_rx_frame_sync <= aux_pulse & (ts == 2'h2);
    end
  end

  // Pin drive enables and bit clock out
  always @(posedge i_mclk) begin
    if (i_srst) begin
      pre_q <= 8'h00;
      o_sck <= 1'b0;
      o_sck_oe <= 1'b0;
      o_tx_frame_sync_oe <= 1'b0;
      o_rx_bit_clock_oe <= 1'b0;
      o_rx_frame_sync_oe <= 1'b0;
      o_wakeup_frame_sync <= 1'b0;
    end else begin
      if (in_tick) begin
        pre_q <= (pre_q == bdiv) ? 8'h00 : pre_q + 8'h01;
      end
      if (int_rise) begin
        o_sck <= 1'b1;
      end else if (int_fall) begin
        o_sck <= 1'b0;
      end
      o_sck_oe <= int_m;
      o_tx_frame_sync_oe <= int_m;
      o_rx_bit_clock_oe <= int_m & sync_m & net_m;
      o_rx_frame_sync_oe <= int_m & sync_m & net_m;
      o_wakeup_frame_sync <= int_m ? o_tx_frame_sync : pin_s2_q[1];
    end
  end

  // Receive frame tracking
  wire rx_start = rx_tx_clk ? tx_start : (pin_s2_q[3] & ~rfs_prev_q);
  wire [6:0] ridx_d = rx_start ? 7'h00 : ((rbit_q == 7'h7F) ? rbit_q : rbit_q + 7'h01);
  wire [6:0] rdec = slot_dec(rbit_q, w16);
  wire [1:0] rs = rdec[5:4];
  wire r_ok = ract_q & en & rdec[6] & (rs <= nslot);
  wire [15:0] rsr_d = {rsr_q[14:0], pin_s2_q[4]};
  wire rx_done = rx_fall & r_ok & (rdec[3:0] == (w16 ? 4'hF : 4'h7));
  wire rx_mine = rx_done & rx_asg[rs];
  wire [15:0] rx_word = w16 ? rsr_d : {8'h00, rsr_d[7:0]};
  wire rx_to_dma = rx_mine & rx_dsel[rs];
  wire rxf_push = rx_mine & ~rx_dsel[rs] & ~rxf_full;
  wire rx_ovr_evt = rx_mine & ~rx_dsel[rs] & rxf_full;

  always @(posedge i_mclk) begin
    if (i_srst) begin
      rbit_q <= 7'h00;
      rfs_prev_q <= 1'b0;
      ract_q <= 1'b0;
      rsr_q <= 16'h0000;
    end else begin
      if (rx_rise) begin
        rbit_q <= ridx_d;
        rfs_prev_q <= pin_s2_q[3];
        ract_q <= en & (ract_q | rx_start);
      end
      if (rx_fall && r_ok) begin
        rsr_q <= rsr_d;
      end
    end
  end

  wire [2:0] w_txd = win(wa, `TXDMA_OFS);
  wire [2:0] r_rxd = win(ra, `RXDMA_OFS);
  wire [2:0] r_txd = win(ra, `TXDMA_OFS);
  wire rxf_pop = rd_en & (ra == `RXF_OFS) & ~rxf_empty;

  // Strobed merges of written registers
  wire [31:0] gcr_m = merge({21'h0, gcr_q}, wd, ws);
  wire [31:0] ccr_m = merge({17'h0, ccr_q}, wd, ws);
  wire [31:0] slot_m = merge({16'h0, slot_q}, wd, ws);
  wire [31:0] csr_m = merge({12'h0, ien_q, 8'h0, thr_q}, wd, ws);
  wire [31:0] txd_m = merge({16'h0, txdma_q[w_txd[1:0]]}, wd, ws);

  // Control registers and sticky flags
  always @(posedge i_mclk) begin
    if (i_srst) begin
      gcr_q <= `GCR_RST;
      ccr_q <= `CCR_RST;
      slot_q <= `SLOT_RST;
      thr_q <= `CSR_THR_RST;
      ien_q <= 4'h0;
      rx_ovr_q <= 1'b0;
      tx_und_q <= 1'b0;
    end else begin
      if (wr_en && wa == `GCR_OFS) begin
        gcr_q <= gcr_m[10:0];
      end
      if (wr_en && wa == `CCR_OFS) begin
        ccr_q <= ccr_m[14:0];
      end
      if (wr_en && wa == `SLOT_OFS) begin
        slot_q <= slot_m[15:0];
      end
      if (wr_en && wa == `CSR_OFS) begin
        thr_q <= csr_m[7:0];
        ien_q <= csr_m[19:16];
      end
      rx_ovr_q <= rx_ovr_evt | (rx_ovr_q & ~(wr_en && wa == `CSR_OFS && wmask[8]));
      tx_und_q <= tx_und_evt | (tx_und_q & ~(wr_en && wa == `CSR_OFS && wmask[10]));
    end
  end

  // Per-slot DMA registers
  always @(posedge i_mclk) begin
    if (i_srst) begin
      txfull_q <= 4'h0;
      rxfull_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        txdma_q[i] <= 16'h0000;
        rxdma_q[i] <= 16'h0000;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (wr_en && w_txd[2] && w_txd[1:0] == i[1:0]) begin
          txdma_q[i] <= txd_m[15:0];
          txfull_q[i] <= 1'b1;
        end else if (tx_load && tx_use_dma && ts == i[1:0]) begin
          txfull_q[i] <= 1'b0;
        end
        if (rx_to_dma && rs == i[1:0]) begin
          rxdma_q[i] <= rx_word;
          rxfull_q[i] <= 1'b1;
        end else if (rd_en && r_rxd[2] && r_rxd[1:0] == i[1:0]) begin
          rxfull_q[i] <= 1'b0;
        end
      end
    end
  end

  wire rx_warn = ({3'h0, rxf_cnt} > {4'h0, thr_q[3:0]}) & ~rx_ovr_q;
  wire tx_warn = ({3'h0, txf_cnt} <= {4'h0, thr_q[7:4]}) & ~tx_und_q;
  wire [3:0] pend = {tx_warn, tx_und_q, rx_warn, rx_ovr_q};

  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
      o_tx_dma_req <= 4'h0;
      o_rx_dma_req <= 4'h0;
    end else begin
      o_irq <= |(pend & ien_q);
      o_tx_dma_req <= {4{en}} & tx_dsel & ~txfull_q;
      o_rx_dma_req <= rxfull_q;
    end
  end

  // Read mux and decode errors
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    wr_err = ~((wa == `GCR_OFS) | (wa == `CCR_OFS) | (wa == `SLOT_OFS) | (wa == `CSR_OFS) |
               (wa == `TXF_OFS) | w_txd[2]);
    if (ra == `GCR_OFS) begin
      rd_data = {21'h0, gcr_q};
    end else if (ra == `CCR_OFS) begin
      rd_data = {17'h0, ccr_q};
    end else if (ra == `SLOT_OFS) begin
      rd_data = {16'h0, slot_q};
    end else if (ra == `CSR_OFS) begin
      rd_data = {2'h0, txf_cnt, rxf_cnt, ien_q, 4'h0, pend, thr_q};
    end else if (ra == `TXF_OFS) begin
      rd_data = 32'h0000_0000;
    end else if (ra == `RXF_OFS) begin
      rd_data = {16'h0, rxf_empty ? 16'h0000 : rxf_rdata};
    end else if (r_txd[2]) begin
      rd_data = {16'h0, txdma_q[r_txd[1:0]]};
    end else if (r_rxd[2]) begin
      rd_data = {16'h0, rxdma_q[r_rxd[1:0]]};
    end else begin
      rd_err = 1'b1;
    end
  end

  axil_reg_port u_port (
    .i_mclk(i_mclk), .i_srst(i_srst),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_wr_en(wr_en), .o_wr_addr(wa), .o_wr_data(wd), .o_wr_strb(ws), .i_wr_err(wr_err),
    .o_rd_en(rd_en), .o_rd_addr(ra), .i_rd_data(rd_data), .i_rd_err(rd_err)
  );

  slot_word_fifo #(.W(16), .AW(FIFO_AW)) u_txf (
    .i_mclk(i_mclk), .i_srst(i_srst),
    .i_push(wr_en && wa == `TXF_OFS && (ws[0] | ws[1])), .i_push_data(wmask[15:0]),
    .i_pop(txf_pop), .o_rd_data(txf_rdata),
    .o_count(txf_cnt), .o_full(), .o_empty(txf_empty)
  );

  slot_word_fifo #(.W(16), .AW(FIFO_AW)) u_rxf (
    .i_mclk(i_mclk), .i_srst(i_srst),
    .i_push(rxf_push), .i_push_data(rx_word),
    .i_pop(rxf_pop), .o_rd_data(rxf_rdata),
    .o_count(rxf_cnt), .o_full(rxf_full), .o_empty(rxf_empty)
  );
endmodule

/* verif/audio_slot_serial_properties.sv */
// Purpose: Port checks of the audio slot block
// Assumes: Internal clocks while drive is on
// Notes: Bound after the module
`timescale 1ns/1ps
module audio_slot_props (
  // Clock, reset and serial pins
  input wire i_mclk, i_srst, o_sck, o_sck_oe, o_tx_frame_sync, o_tx_frame_sync_oe, o_wakeup_frame_sync,
  input wire o_rx_bit_clock, o_rx_bit_clock_oe, o_rx_frame_sync, o_rx_frame_sync_oe,
  input wire o_serial_tx_data, o_serial_tx_data_oe
);
  reg [7:0] cnt_q;
  // Bit rises while sync high
  always @(posedge i_mclk) begin
    if (!o_tx_frame_sync) cnt_q <= 8'h00;
    else if ($rose(o_sck)) cnt_q <= cnt_q + 8'h01;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  AST_OE_PAIR: assert property (o_sck_oe == o_tx_frame_sync_oe)
    else $error("clock drives differ");
  AST_RX_OE: assert property (o_rx_bit_clock_oe |-> o_sck_oe)
    else $error("extra sync without clocks");
  AST_RX_PAIR: assert property (o_rx_bit_clock_oe == o_rx_frame_sync_oe)
    else $error("extra drives differ");
  AST_OE_RISE: assert property (o_sck_oe && $changed(o_serial_tx_data_oe) |-> o_sck)
    else $error("data drive off rise");
  AST_TXD: assert property (o_sck_oe && o_serial_tx_data_oe && $changed(o_serial_tx_data) |-> o_sck)
    else $error("data off rise");
  AST_FSL: assert property ($fell(o_tx_frame_sync) && o_sck_oe |-> cnt_q inside {6, 13, 14, 15, 16})
    else $error("bad sync length");
  AST_XSYNC: assert property ($rose(o_rx_bit_clock) |-> !$rose(o_rx_frame_sync) && !$rose(o_tx_frame_sync))
    else $error("extra syncs collide");
  AST_WAKE: assert property ($changed(o_tx_frame_sync) && o_sck_oe |-> ##[0:2] (o_wakeup_frame_sync == o_tx_frame_sync))
    else $error("wake copy lost");
endmodule
bind audio_slot_serial audio_slot_props i_audio_slot_props (.i_mclk, .i_srst, .o_sck, .o_sck_oe,
  .o_tx_frame_sync, .o_tx_frame_sync_oe, .o_wakeup_frame_sync, .o_rx_bit_clock, .o_rx_bit_clock_oe,
  .o_rx_frame_sync, .o_rx_frame_sync_oe, .o_serial_tx_data, .o_serial_tx_data_oe);

/* verif/codec_model.sv */
// Purpose: Codec answering slot 0
// Assumes: Bit clock slower than mclk
// Notes: Idle line toggles each bit
`timescale 1ns/1ps
module codec_model (
  // Link
  input wire i_mclk, i_bclk, i_fs, i_sd,
  input wire [15:0] i_word,
  // Results
  output reg o_sd = 1'b0,
  output reg [15:0] o_cap = 16'h0000
);
  int n = 99;
  reg pb = 1'b0, pf = 1'b0;
  always @(posedge i_mclk) begin
    pb <= i_bclk;
    if (i_bclk && !pb) begin
      pf <= i_fs;
      n = (i_fs && !pf) ? 0 : n + 1;
      o_sd <= (n < 16) ? i_word[15 - n] : ~o_sd;
    end
    if (!i_bclk && pb && n < 16) o_cap <= {o_cap[14:0], i_sd};
  end
endmodule

/* verif/audio_slot_serial_tb_top.sv */
// Purpose: Bench of the audio slot block
// Assumes: Pins looped back, codec on slot 0
// Notes: 32-bit frames, 8 clocks a bit
`timescale 1ns/1ps
module audio_slot_serial_tb_top;
  reg clk = 0, rst = 1, aux = 0, pll = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  reg [1:0] ph = 2'h0, rs, bs;
  reg [7:0] aa = 8'h00, ra = 8'h00;
  reg [31:0] wd = 32'h0000_0000, rv;
  wire awr, wrd, bv, arr, rvl, sck, fs, rbc, rfs, sd, sdo, irq;
  wire [1:0] rresp, bresp;
  wire [31:0] rdat;
  wire [3:0] tdr, rdr;
  wire [15:0] cap;
  int err_total = 0, total_checks = 0, n;
  // Clock and source strobes
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    aux <= (ph == 2'h3);
    pll <= ~pll;
  end
  audio_slot_serial i_audio_slot_serial (.i_mclk(clk), .i_srst(rst), .i_aux_tick(aux), .i_pll_tick(pll),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(aa), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd),
    .i_wstrb(4'hF), .o_bvalid(bv), .i_bready(br), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ra), .o_rvalid(rvl), .i_rready(rr), .o_rdata(rdat), .o_rresp(rresp), .i_sck(sck),
    .o_sck(sck), .o_sck_oe(), .i_tx_frame_sync(fs), .o_tx_frame_sync(fs), .o_tx_frame_sync_oe(),
    .i_rx_bit_clock(rbc), .o_rx_bit_clock(rbc), .o_rx_bit_clock_oe(), .i_rx_frame_sync(rfs),
    .o_rx_frame_sync(rfs), .o_rx_frame_sync_oe(), .o_serial_tx_data(sdo), .o_serial_tx_data_oe(),
    .i_serial_rx_data(sd), .o_irq(irq), .o_wakeup_frame_sync(), .o_tx_dma_req(tdr), .o_rx_dma_req(rdr));
  codec_model i_codec_model (.i_mclk(clk), .i_bclk(sck), .i_fs(fs), .i_sd(sdo), .i_word(16'h5A3C),
    .o_sd(sd), .o_cap(cap));
  task end_sim;
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task tmo;
    err_total++;
    end_sim;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    int k;
    @(posedge clk);
    aa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    br <= 1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
      if (bv) break;
    end
    bs = bresp;
    br <= 0;
    if (k == 40) tmo;
  endtask
  task rd(input [7:0] a);
    int k;
    @(posedge clk);
    ra <= a;
    arv <= 1;
    rr <= 1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rvl) break;
    end
    rv = rdat;
    rs = rresp;
    rr <= 0;
    if (k == 40) tmo;
  endtask
  // Cycles until the chosen sync rises
  task wfs(input s);
    n = 0;
    while ((s ? rfs : fs) && n < 600) begin
      @(posedge clk);
      n++;
    end
    while (!(s ? rfs : fs) && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) tmo;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rd(8'h04);
    chk(rv, 32'h0000_0F01);
    rd(8'h40);
    chk(rs, 2'h2);
    wr(8'h04, 32'h0000_1F01);
    chk(bs, 2'h0);
    wr(8'h08, 32'h0000_0011);
    wr(8'h0C, 32'h000F_0010);
    wr(8'h10, 32'h0000_A5C3);
    wr(8'h10, 32'h0000_1234);
    wr(8'h00, 32'h0000_0063);
    wfs(0);
    wfs(0);
    chk(n, 256);
    chk(cap, 16'hA5C3);
    wfs(0);
    chk(cap, 16'h1234);
    wfs(0);
    chk(cap, 16'h1234);
    rd(8'h0C);
    chk(rv[11:8], 4'h6);
    chk(irq, 1'b1);
    rd(8'h14);
    chk(rv, 32'h0000_5A3C);
    wr(8'h08, 32'h0000_1111);
    @(posedge clk);
    chk(tdr, 4'h1);
    wr(8'h18, 32'h0000_BEEF);
    @(posedge clk);
    chk(tdr, 4'h0);
    wfs(0);
    wfs(0);
    chk(cap, 16'hBEEF);
    chk(rdr, 4'h1);
    rd(8'h28);
    chk(rv, 32'h0000_5A3C);
    wfs(0);
    chk(cap, 16'hBEEF);
    for (int c = 0; c < 5; c++) begin
      wr(8'h00, 32'h0000_0063 | (c << 8));
      wfs(0);
      wfs(0);
    end
    wr(8'h00, 32'h0000_045F);
    wfs(0);
    wfs(1);
    chk(n, 128);
    // Faster source: 4 clocks a bit
    wr(8'h00, 32'h0000_00E3);
    wfs(0);
    wfs(0);
    chk(n, 128);
    end_sim;
  end
endmodule
